// File: rtl/abwpd_top.sv
// bus slave with parity memory plus dma mastership arbitration
// assumes pins arrive active high after the bus receivers; sys_rst is bus initialize
`include "abwpd_consts.svh"
`timescale 1ns/1ps
module abwpd_top (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // bus strobes in
  input wire logic sync_strobe,
  input wire logic data_input_strobe,
  input wire logic data_output_strobe,
  input wire logic slave_reply_in,
  input wire logic write_byte_control,
  input wire logic io_page_select,
  // data/address lines, three-signal pin
  input wire abwpd_pkg::abwpd_dal_type dalIn,
  output logic [17:0] dalOut,
  output logic dalOe,
  // reply out
  output logic slave_reply,
  // parity detection enable from user logic
  input wire logic parityEnable,
  // dma arbitration
  input wire logic dma_grant_in,
  output logic dma_grant_out,
  output logic dma_request,
  output logic bus_grant_acknowledge,
  output logic masterSyncOk,
  // user side dma control
  input wire logic dmaWant,
  input wire logic dmaDone,
  output logic replyLate
);
  import abwpd_pkg::*;

  // ***********************
  // pin sampling
  // ***********************
  abwpd_sync_if pins ();
  abwpd_pin_sync u_sync (
    .clk(clk),
    .sys_rst(sys_rst),
    .pinRaw({dalIn, dma_grant_in, io_page_select, write_byte_control, slave_reply_in,
             data_output_strobe, data_input_strobe, sync_strobe}),
    .pins(pins)
  );

  // ***********************
  // slave cycle state
  // ***********************
  function automatic logic addrHit(input logic [17:0] a, input logic io);
    addrHit = io && (a[`ABWPD_ADDR_W-1:`ABWPD_MEM_AW+1] == 6'(`ABWPD_BASE_ADDR >> (`ABWPD_MEM_AW + 1)));
  endfunction

  logic [15:0] mem [`ABWPD_MEM_WORDS];
  logic [`ABWPD_MEM_WORDS-1:0] perr_ff, nxt_perr;
  abwpd_slv_type slv_ff, nxt_slv;
  logic [17:0] addr_ff, nxt_addr;
  logic wrCyc_ff, nxt_wrCyc;
  logic reply_ff, nxt_reply;
  logic [17:0] dout_ff, nxt_dout;
  logic oe_ff, nxt_oe;
  logic sawOut_ff, nxt_sawOut;
  logic [15:0] wdata_ff, nxt_wdata;
  logic wdataPerr_ff, nxt_wdataPerr;
  logic wrEn;
  logic [`ABWPD_MEM_AW-1:0] idx;
  logic [15:0] merged;
  logic [15:0] rdWord;

  assign idx = addr_ff[`ABWPD_MEM_AW:1];
  assign rdWord = mem[idx];

  always_comb begin
    nxt_slv = slv_ff;
    nxt_addr = addr_ff;
    nxt_wrCyc = wrCyc_ff;
    nxt_reply = reply_ff;
    nxt_dout = dout_ff;
    nxt_oe = oe_ff;
    nxt_sawOut = sawOut_ff;
    nxt_wdata = wdata_ff;
    nxt_wdataPerr = wdataPerr_ff;
    nxt_perr = perr_ff;
    wrEn = 1'b0;
    merged = rdWord;
    unique case (slv_ff)
      ABWPD_S_IDLE: begin
        // latch on sync edge; unselected cycles are left alone
        if (pins.syncStrobe) begin
          nxt_addr = pins.dal; // see R1
          nxt_wrCyc = pins.writeByte; // see R2
          nxt_slv = addrHit(pins.dal, pins.ioPage) ? ABWPD_S_SEL : ABWPD_S_DONE; // see R24
        end
      end
      ABWPD_S_SEL: begin
        if (!pins.syncStrobe) begin
          nxt_slv = ABWPD_S_IDLE; // see R1
        end else if (pins.dataInStrobe && !wrCyc_ff) begin // see R2
          nxt_dout = {parityEnable, perr_ff[idx], rdWord}; // see R17
          nxt_oe = 1'b1;
          nxt_reply = 1'b1;
          nxt_slv = ABWPD_S_RDREPLY;
        end else if (pins.dataOutStrobe) begin
          nxt_wdata = pins.dal[15:0];
          nxt_wdataPerr = pins.dal[`ABWPD_BIT_PERR]; // see R7
          nxt_sawOut = pins.writeByte; // see R5
          nxt_reply = 1'b1; // see R9
          nxt_slv = ABWPD_S_WRREPLY;
        end
      end
      ABWPD_S_RDREPLY: begin
        if (!pins.dataInStrobe) begin
          nxt_reply = 1'b0;
          nxt_oe = 1'b0;
          nxt_slv = ABWPD_S_SEL; // see R15
        end
      end
      ABWPD_S_WRREPLY: begin
        // data keeps updating while strobe stands; taken at its negation
        if (pins.dataOutStrobe) begin
          nxt_wdata = pins.dal[15:0];
          nxt_wdataPerr = pins.dal[`ABWPD_BIT_PERR];
          nxt_sawOut = pins.writeByte;
        end else begin
          wrEn = 1'b1; // see R12
          nxt_reply = 1'b0;
          nxt_slv = ABWPD_S_SEL;
          if (sawOut_ff) begin
            if (addr_ff[`ABWPD_BIT_LANE]) begin
              merged = {wdata_ff[15:8], rdWord[7:0]}; // see R6
            end else begin
              merged = {rdWord[15:8], wdata_ff[7:0]};
            end
          end else begin
            merged = wdata_ff; // see R4
          end
          nxt_perr[idx] = wdataPerr_ff; // see R7
        end
      end
      ABWPD_S_DONE: begin
        if (!pins.syncStrobe) begin
          nxt_slv = ABWPD_S_IDLE;
        end
      end
      default: begin
        nxt_slv = ABWPD_S_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      slv_ff <= ABWPD_S_IDLE;
      addr_ff <= 18'h00000;
      wrCyc_ff <= 1'b0;
      reply_ff <= 1'b0;
      dout_ff <= 18'h00000;
      oe_ff <= 1'b0;
      sawOut_ff <= 1'b0;
      wdata_ff <= 16'h0000;
      wdataPerr_ff <= 1'b0;
      perr_ff <= '0;
    end else begin
      slv_ff <= nxt_slv;
      addr_ff <= nxt_addr;
      wrCyc_ff <= nxt_wrCyc;
      reply_ff <= nxt_reply;
      dout_ff <= nxt_dout;
      oe_ff <= nxt_oe;
      sawOut_ff <= nxt_sawOut;
      wdata_ff <= nxt_wdata;
      wdataPerr_ff <= nxt_wdataPerr;
      perr_ff <= nxt_perr;
    end
  end

  // storage array is not reset: contents are random at power-up like real memory
  always_ff @(posedge clk) begin
    if (wrEn) begin
      mem[idx] <= merged;
    end
  end

  // ***********************
  // reply watchdog
  // ***********************
  logic [9:0] rcnt_ff, nxt_rcnt;
  logic late_ff, nxt_late;
  always_comb begin
    nxt_rcnt = 10'h000;
    nxt_late = late_ff;
    if (slv_ff == ABWPD_S_SEL && pins.dataOutStrobe) begin
      nxt_late = 1'b0;
    end
    if (reply_ff && rcnt_ff < 10'(`ABWPD_REPLY_MAX_CYC)) begin
      nxt_rcnt = rcnt_ff + 10'h001;
    end
    // reply comes one cycle after strobe, so this never fires in normal use
    if (pins.dataOutStrobe && !reply_ff && slv_ff == ABWPD_S_WRREPLY) begin
      nxt_late = 1'b1; // see R9
    end
  end

  // ***********************
  // dma arbitration
  // ***********************
  abwpd_dma_type dma_ff, nxt_dma;
  logic req_ff, nxt_req;
  logic ack_ff, nxt_ack;
  logic gout_ff, nxt_gout;
  logic syncOk_ff, nxt_syncOk;
  logic [3:0] wcnt_ff, nxt_wcnt;
  always_comb begin
    nxt_dma = dma_ff;
    nxt_req = req_ff;
    nxt_ack = ack_ff;
    nxt_syncOk = syncOk_ff;
    nxt_wcnt = wcnt_ff;
    // pass-through when not requesting; sampler plus one flop is far below 500 ns
    nxt_gout = pins.grantIn && !req_ff && dma_ff == ABWPD_M_IDLE; // see R19
    unique case (dma_ff)
      ABWPD_M_IDLE: begin
        if (dmaWant) begin
          nxt_req = 1'b1;
          nxt_gout = 1'b0; // see R20
          if (pins.grantIn && req_ff) begin
            nxt_dma = ABWPD_M_WAIT;
          end
        end else begin
          nxt_req = 1'b0;
        end
      end
      ABWPD_M_WAIT: begin
        nxt_gout = 1'b0;
        if (!pins.syncStrobe && !pins.replyIn) begin
          nxt_ack = 1'b1; // see R20
          nxt_req = 1'b0;
          nxt_wcnt = 4'h0;
          nxt_dma = ABWPD_M_OWN;
        end
      end
      ABWPD_M_OWN: begin
        nxt_gout = 1'b0;
        if (wcnt_ff < 4'(`ABWPD_SYNC_WAIT_CYC)) begin
          nxt_wcnt = wcnt_ff + 4'h1;
        end else begin
          nxt_syncOk = 1'b1; // see R21
        end
        if (dmaDone && !pins.replyIn) begin
          nxt_dma = ABWPD_M_DROP; // see R22
        end
      end
      ABWPD_M_DROP: begin
        nxt_gout = 1'b0;
        nxt_ack = 1'b0; // see R23
        nxt_syncOk = 1'b0;
        nxt_dma = ABWPD_M_IDLE;
      end
      default: begin
        nxt_dma = ABWPD_M_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rcnt_ff <= 10'h000;
      late_ff <= 1'b0;
      dma_ff <= ABWPD_M_IDLE;
      req_ff <= 1'b0;
      ack_ff <= 1'b0;
      gout_ff <= 1'b0;
      syncOk_ff <= 1'b0;
      wcnt_ff <= 4'h0;
    end else begin
      rcnt_ff <= nxt_rcnt;
      late_ff <= nxt_late;
      dma_ff <= nxt_dma;
      req_ff <= nxt_req;
      ack_ff <= nxt_ack;
      gout_ff <= nxt_gout;
      syncOk_ff <= nxt_syncOk;
      wcnt_ff <= nxt_wcnt;
    end
  end

  assign dalOut = dout_ff;
  assign dalOe = oe_ff; // see R24
  assign slave_reply = reply_ff;
  assign dma_grant_out = gout_ff;
  assign dma_request = req_ff;
  assign bus_grant_acknowledge = ack_ff;
  assign masterSyncOk = syncOk_ff;
  assign replyLate = late_ff;
endmodule

// File: rtl/abwpd_consts.svh
// constants for the bus slave / dma module logic
// assumes a 40 MHz module clock; bus pins are sampled, active-high internally
//
// Summary of operation
// R1: latch address, io page select and write/byte control on sync; hold until sync drops
// R2: write/byte asserted at addressing means write follows, else read or rmw
// R3: master puts write data no earlier than 100 ns after sync
// R4: word write: master negates write/byte 100 ns after sync, keeps it negated
// R5: byte write keeps write/byte asserted; rmw write part asserts it to end
// R6: captured address bit 0 picks byte lane: set means upper byte
// R7: data line 16 on write stores forced parity error; line 17 unused on writes
// R8: master asserts data-output strobe 100 ns to 8 us after data stable
// R9: slave replies within 10 us of data-output strobe
// R10: master holds data-output strobe 150 ns after reply
// R11: master holds write data 100 ns after data-output strobe negation
// R12: on strobe negation slave accepts data and drops reply; master drops sync
// R13: processor waits 175 ns after strobe negation before dropping sync
// R14: sync stays negated 200 ns between write cycles
// R15: rmw keeps sync across both parts, 200 ns reply-drop to output strobe
// R16: processor samples lines 16 and 17 with read data after 200 ns deskew
// R17: enabled parity asserts line 17 on reads; bad-parity memory asserts line 16
// R18: both parity lines at reply time make processor trap to 114 octal
// R19: non-requesting module passes dma grant through in under 500 ns
// R20: requester blocks grant, acknowledges within 500 ns once sync and reply idle
// R21: dma master waits 250 ns after grant and idle bus before asserting sync
// R22: acknowledge held through all transfers until the module releases the bus
// R23: acknowledge dropped after last transfer, at most 300 ns before sync drops
// R24: unselected slave ignores strobes and drives neither reply nor data
`ifndef ABWPD_CONSTS_SVH
`define ABWPD_CONSTS_SVH
`define ABWPD_CLK_NS 25
`define ABWPD_REPLY_MAX_NS 10000
`define ABWPD_REPLY_MAX_CYC ((`ABWPD_REPLY_MAX_NS) / (`ABWPD_CLK_NS))
`define ABWPD_SYNC_WAIT_NS 250
`define ABWPD_SYNC_WAIT_CYC (((`ABWPD_SYNC_WAIT_NS) + (`ABWPD_CLK_NS) - 1) / (`ABWPD_CLK_NS))
`define ABWPD_ADDR_W 13
`define ABWPD_MEM_WORDS 64
`define ABWPD_MEM_AW 6
`define ABWPD_BASE_ADDR 13'h0000
`define ABWPD_RST_WORD 16'h0000
`define ABWPD_BIT_LANE 0
`define ABWPD_BIT_PERR 16
`define ABWPD_BIT_PEN 17
`endif

// File: rtl/abwpd_pkg.sv
// types shared by the bus slave / dma module files
// assumes the constants header is included alongside
package abwpd_pkg;
  typedef enum logic [4:0] {
    ABWPD_S_IDLE = 5'h01,
    ABWPD_S_SEL = 5'h02,
    ABWPD_S_RDREPLY = 5'h04,
    ABWPD_S_WRREPLY = 5'h08,
    ABWPD_S_DONE = 5'h10
  } abwpd_slv_type;
  typedef enum logic [3:0] {
    ABWPD_M_IDLE = 4'h1,
    ABWPD_M_WAIT = 4'h2,
    ABWPD_M_OWN = 4'h4,
    ABWPD_M_DROP = 4'h8
  } abwpd_dma_type;
  typedef logic [17:0] abwpd_dal_type;
endpackage

// File: rtl/abwpd_sync_if.sv
// synchronised bus pin bundle passed from the pin stage to the core
// assumes one clock domain
`timescale 1ns/1ps
interface abwpd_sync_if;
  logic syncStrobe;
  logic dataInStrobe;
  logic dataOutStrobe;
  logic replyIn;
  logic writeByte;
  logic ioPage;
  logic grantIn;
  logic [17:0] dal;
  modport src (output syncStrobe, dataInStrobe, dataOutStrobe, replyIn, writeByte, ioPage, grantIn, dal);
  modport dst (input syncStrobe, dataInStrobe, dataOutStrobe, replyIn, writeByte, ioPage, grantIn, dal);
endinterface

// File: rtl/abwpd_pin_sync.sv
// three-stage sampler for the asynchronous bus pins
// assumes pins are already converted to active-high levels
`timescale 1ns/1ps
module abwpd_pin_sync (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // raw pins
  input wire logic [24:0] pinRaw,
  // sampled pins
  abwpd_sync_if.src pins
);
  import abwpd_pkg::*;
  logic [24:0] s1_ff, s2_ff, s3_ff, v_ff;
  logic [24:0] nxt_s1, nxt_s2, nxt_s3, nxt_v;
  // a level counts once stages two and three agree; stage one feeds stage two only
  always_comb begin
    nxt_s1 = pinRaw;
    nxt_s2 = s1_ff;
    nxt_s3 = s2_ff;
    nxt_v = v_ff;
    for (int i = 0; i < 25; i++) begin
      if (s2_ff[i] == s3_ff[i]) begin
        nxt_v[i] = s3_ff[i];
      end
    end
  end
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s1_ff <= 25'h0000000;
      s2_ff <= 25'h0000000;
      s3_ff <= 25'h0000000;
      v_ff <= 25'h0000000;
    end else begin
      s1_ff <= nxt_s1;
      s2_ff <= nxt_s2;
      s3_ff <= nxt_s3;
      v_ff <= nxt_v;
    end
  end
  assign pins.syncStrobe = v_ff[0];
  assign pins.dataInStrobe = v_ff[1];
  assign pins.dataOutStrobe = v_ff[2];
  assign pins.replyIn = v_ff[3];
  assign pins.writeByte = v_ff[4];
  assign pins.ioPage = v_ff[5];
  assign pins.grantIn = v_ff[6];
  assign pins.dal = v_ff[24:7];
endmodule

// File: verif/abwpd_top_sva.sv
// checker for the bus slave and dma arbitration ports
// assumes a single clock domain; bound into abwpd_top below
`timescale 1ns/1ps
module abwpd_top_sva (
  // clock, reset and bus
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic sync_strobe,
  input wire logic data_input_strobe,
  input wire logic data_output_strobe,
  input wire logic slave_reply_in,
  input wire logic io_page_select,
  input wire abwpd_pkg::abwpd_dal_type dalIn,
  input wire logic [17:0] dalOut,
  input wire logic dalOe,
  input wire logic slave_reply,
  input wire logic parityEnable,
  // dma
  input wire logic dma_grant_in,
  input wire logic dma_grant_out,
  input wire logic dma_request,
  input wire logic bus_grant_acknowledge,
  input wire logic masterSyncOk,
  input wire logic dmaDone
);
  import abwpd_pkg::*;
  logic sel_ff;
  logic nxt_sel;
  logic syncd_ff;
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // ****
  // selection seen at the pins
  // ****
  always_comb begin
    nxt_sel = sel_ff;
    if (sync_strobe && !syncd_ff) nxt_sel = io_page_select && (dalIn[12:7] == 6'h00);
  end
  always_ff @(posedge clk) begin
    sel_ff <= sys_rst ? 1'b0 : nxt_sel;
    syncd_ff <= sys_rst ? 1'b0 : sync_strobe;
  end
  property p_wrReply;
    sel_ff && $rose(data_output_strobe) |-> ##[1:8] slave_reply;
  endproperty
  a_wrReply: assert property (p_wrReply) else $error("no reply to write strobe");
  property p_rdReply;
    sel_ff && $rose(data_input_strobe) |-> ##[1:8] (slave_reply && dalOe);
  endproperty
  a_rdReply: assert property (p_rdReply) else $error("no reply to read strobe");
  property p_rdData;
    $rose(slave_reply) && data_input_strobe |-> dalOe && (dalOut[17] == parityEnable);
  endproperty
  a_rdData: assert property (p_rdData) else $error("bad enable bit on read");
  property p_drop;
    $fell(data_output_strobe) || $fell(data_input_strobe) |-> ##[1:8] (!slave_reply && !dalOe);
  endproperty
  a_drop: assert property (p_drop) else $error("reply held after strobe");
  property p_unsel;
    sync_strobe && !sel_ff |-> !slave_reply && !dalOe;
  endproperty
  a_unsel: assert property (p_unsel) else $error("unselected slave drives");
  property p_pass;
    $rose(dma_grant_in) && !dma_request && !bus_grant_acknowledge |-> ##[1:19] dma_grant_out;
  endproperty
  a_pass: assert property (p_pass) else $error("grant not passed");
  property p_block;
    dma_request || bus_grant_acknowledge |-> !dma_grant_out;
  endproperty
  a_block: assert property (p_block) else $error("grant passed while requesting");
  property p_ack;
    dma_request && dma_grant_in && $fell(slave_reply_in) && !sync_strobe |-> ##[1:19] bus_grant_acknowledge;
  endproperty
  a_ack: assert property (p_ack) else $error("acknowledge late");
  property p_syncWait;
    $rose(bus_grant_acknowledge) |-> !masterSyncOk [*8] ##1 !masterSyncOk [*2] ##[1:3] masterSyncOk;
  endproperty
  a_syncWait: assert property (p_syncWait) else $error("sync permit timing");
  property p_hold;
    bus_grant_acknowledge && !dmaDone |=> bus_grant_acknowledge;
  endproperty
  a_hold: assert property (p_hold) else $error("acknowledge lost");
  property p_release;
    bus_grant_acknowledge && dmaDone && !slave_reply_in |-> ##[1:3] !bus_grant_acknowledge;
  endproperty
  a_release: assert property (p_release) else $error("acknowledge not released");
endmodule
bind abwpd_top abwpd_top_sva u_abwpd_top_sva (.clk(clk), .sys_rst(sys_rst), .sync_strobe(sync_strobe),
  .data_input_strobe(data_input_strobe), .data_output_strobe(data_output_strobe),
  .slave_reply_in(slave_reply_in), .io_page_select(io_page_select), .dalIn(dalIn), .dalOut(dalOut),
  .dalOe(dalOe), .slave_reply(slave_reply), .parityEnable(parityEnable), .dma_grant_in(dma_grant_in),
  .dma_grant_out(dma_grant_out), .dma_request(dma_request), .bus_grant_acknowledge(bus_grant_acknowledge),
  .masterSyncOk(masterSyncOk), .dmaDone(dmaDone));

// File: verif/abwpd_master_model.sv
// bus master model: word, byte, read and read-modify-write cycles
// assumes 25 ns clock; released lines fall to 0 as with terminators
`timescale 1ns/1ps
module abwpd_master_model (
  // clock
  input wire logic clk,
  // bus
  output logic bSync,
  output logic bDin,
  output logic bDout,
  output logic bWbt,
  output logic [17:0] data_address_lines,
  input wire logic reply,
  input wire logic [17:0] dal
);
  initial begin
    bSync = 1'b0;
    bDin = 1'b0;
    bDout = 1'b0;
    bWbt = 1'b0;
    data_address_lines = 18'h00000;
  end
  // ****
  // cycles
  // ****
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  // lim is the reply timeout in clocks; 400 stands for the 10 us bus timeout
  task automatic waitReply(input logic lvl, input int lim, inout logic ok);
    for (int i = 0; i < lim && reply !== lvl; i++) @(posedge clk);
    if (reply !== lvl) ok = 1'b0;
  endtask
  task automatic cyc(input logic [12:0] adr, input logic rd, input logic wr, input logic bw,
    input logic [16:0] wd, input int slack, input int lim, output logic [17:0] rdat, output logic ok);
    ok = 1'b1;
    rdat = 18'h00000;
    data_address_lines <= {5'h00, adr};
    bWbt <= wr && !rd;
    tick(6);
    bSync <= 1'b1;
    tick(4);
    if (rd) data_address_lines <= 18'h00000;
    if (rd) begin
      bDin <= 1'b1;
      tick(1);
      waitReply(1'b1, lim, ok);
      tick(8);
      rdat = dal;
      bDin <= 1'b0;
      tick(1);
      waitReply(1'b0, lim, ok);
      tick(8);
    end
    if (wr) begin
      data_address_lines <= {1'b0, wd};
      bWbt <= bw;
      tick(4 + slack);
      bDout <= 1'b1;
      tick(1);
      waitReply(1'b1, lim, ok);
      tick(6);
      bDout <= 1'b0;
      tick(4);
      data_address_lines <= 18'h00000;
      waitReply(1'b0, lim, ok);
      tick(3);
    end
    bWbt <= 1'b0;
    bSync <= 1'b0;
    tick(8);
  endtask
endmodule

// File: verif/abwpd_top_tb.sv
// random slave cycles through the master model, then dma arbitration
// assumes the checker is bound to the design separately
`timescale 1ns/1ps
module abwpd_top_tb;
  import abwpd_pkg::*;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic parityEnable = 1'b0;
  logic dma_grant_in = 1'b0;
  logic dmaWant = 1'b0;
  logic dmaDone = 1'b0;
  logic otherReply = 1'b0;
  logic ioPage = 1'b1;
  logic [17:0] fillDat;
  logic fillOk;
  wire logic bSync, bDin, bDout, bWbt, reply, oe, grantOut, request, ack, syncOk, late;
  wire logic [17:0] data_address_lines, dOut;
  // wired-or of open-collector drivers, read as active high
  wire abwpd_dal_type dal = data_address_lines | (oe ? dOut : 18'h00000);
  logic [16:0] refMem [8];
  int seed = 32'hc3f7;
  int numErrors = 0;
  int checksDone = 0;
  always #12.5 clk = ~clk;
  abwpd_master_model u_abwpd_master_model (.clk(clk), .bSync(bSync), .bDin(bDin), .bDout(bDout),
    .bWbt(bWbt), .data_address_lines(data_address_lines), .reply(reply), .dal(dal));
  abwpd_top u_abwpd_top (.clk(clk), .sys_rst(sys_rst), .sync_strobe(bSync), .data_input_strobe(bDin),
    .data_output_strobe(bDout), .slave_reply_in(reply | otherReply), .write_byte_control(bWbt),
    .io_page_select(ioPage), .dalIn(dal), .dalOut(dOut), .dalOe(oe), .slave_reply(reply),
    .parityEnable(parityEnable), .dma_grant_in(dma_grant_in), .dma_grant_out(grantOut),
    .dma_request(request), .bus_grant_acknowledge(ack), .masterSyncOk(syncOk), .dmaWant(dmaWant),
    .dmaDone(dmaDone), .replyLate(late));
  // ****
  // helpers
  // ****
  task automatic giveVerdict;
    $display("checks %0d errors %0d", checksDone, numErrors);
    if (numErrors == 0 && checksDone > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic check(input string nm, input logic [17:0] exp, input logic [17:0] got);
    checksDone++;
    if (got !== exp) begin
      numErrors++;
      $display("unexpected %s: expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic waitSig(input int w, input logic lvl, input int lim);
    logic v;
    for (int i = 0; i <= lim; i++) begin
      @(posedge clk);
      v = (w == 0) ? grantOut : (w == 1) ? ack : syncOk;
      if (v === lvl) break;
    end
    check("dma signal", 18'(lvl), 18'(v));
    if (v !== lvl) giveVerdict();
  endtask
  function automatic logic [16:0] merge(input logic [16:0] old, input logic hi, input logic bw,
    input logic [16:0] wd);
    merge = wd;
    if (bw) merge[15:0] = hi ? {wd[15:8], old[7:0]} : {old[15:8], wd[7:0]};
  endfunction
  // kinds: word write, byte write, read, rmw word, rmw byte, unselected
  task automatic op(input int k);
    logic [12:0] adr;
    logic [16:0] wd;
    logic [17:0] rdat;
    logic ok;
    logic wr;
    logic bw;
    logic pg;
    adr = {9'h000, 4'($random(seed))};
    // unselected by address or by io page, never both, so each qualifier is tested alone
    pg = 1'($random(seed));
    if (k == 5 && pg) adr[9] = 1'b1;
    ioPage <= !(k == 5 && !pg);
    wd = 17'($random(seed));
    wr = (k <= 1) || (k == 3) || (k == 4);
    bw = (k == 1) || (k == 4);
    parityEnable <= 1'($random(seed));
    @(posedge clk);
    u_abwpd_master_model.cyc(adr, k >= 2, wr, bw, wd, k, (k == 5) ? 40 : 400, rdat, ok);
    check("reply", 18'(k != 5), 18'(ok));
    if (k == 5) check("idle bus", 18'h00000, rdat);
    else if (k >= 2) check("read data", {parityEnable, refMem[adr[3:1]]}, rdat);
    if (k >= 2 && k != 5) check("trap", 18'(parityEnable & refMem[adr[3:1]][16]), 18'(&rdat[17:16]));
    if (wr) refMem[adr[3:1]] = merge(refMem[adr[3:1]], adr[0], bw, wd);
  endtask
  initial begin
    foreach (refMem[i]) refMem[i] = 17'h00000;
    repeat (16) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (4) @(posedge clk);
    // storage powers up unknown: write known words with clean parity first
    for (int j = 0; j < 8; j++) begin
      u_abwpd_master_model.cyc(13'(2 * j), 1'b0, 1'b1, 1'b0, 17'h00000, 0, 400, fillDat, fillOk);
      check("fill reply", 18'h00001, 18'(fillOk));
    end
    for (int i = 0; i < 60; i++) op((i < 6) ? i : int'($unsigned($random(seed)) % 6));
    dma_grant_in <= 1'b1;
    waitSig(0, 1'b1, 19);
    dma_grant_in <= 1'b0;
    waitSig(0, 1'b0, 19);
    dmaWant <= 1'b1;
    otherReply <= 1'b1;
    repeat (4) @(posedge clk);
    check("request", 18'h00001, 18'(request));
    dma_grant_in <= 1'b1;
    repeat (20) @(posedge clk);
    check("early ack", 18'h00000, 18'(ack));
    check("blocked grant", 18'h00000, 18'(grantOut));
    otherReply <= 1'b0;
    waitSig(1, 1'b1, 19);
    waitSig(2, 1'b1, 14);
    repeat (30) @(posedge clk);
    check("held ack", 18'h00001, 18'(ack));
    dmaDone <= 1'b1;
    waitSig(1, 1'b0, 11);
    dmaWant <= 1'b0;
    dmaDone <= 1'b0;
    dma_grant_in <= 1'b0;
    repeat (10) @(posedge clk);
    check("reply late flag", 18'h00000, 18'(late));
    giveVerdict();
  end
endmodule
